//--- core/amd_decoder.sv
`timescale 1ns/1ps

// Behaviour
// - Full 32-bit linear byte space decoded
// - Read window top-aligned, base by capacity
// - Programming alias ends at 00FFFFFF
// - RAM from zero, top by capacity
// - Access depends on controls only, not on mode
// - Boot modes use single-chip map
// - Peripheral writes are posted
// - Latency counted in reference clock cycles
module amd_decoder
   import amd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Configuration
   input  wire logic [2:0]  romSize,
   input  wire logic [1:0]  ramSize,
   input  wire amd_mode_t   opMode,
   input  wire logic        romEnable,
   input  wire logic        progEnable,
   input  wire logic        periphEnable,
   // Reference clock tick and latency for the addressed register
   input  wire logic        refTick,
   input  wire logic [3:0]  periphLat,
   // Initiator port
   input  wire amd_req_t    req,
   output logic             reqReady,
   output logic             rspValid,
   output logic [31:0]      rspData,
   output amd_region_t      rspRegion,
   output logic             romWriteErr,
   // Peripheral port
   output amd_preq_t        periphReq,
   input  wire logic [31:0] periphRdata
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************

   // The map is a pure decode of the address and the static controls

   // Read window base for a capacity code
   // Smaller parts start higher, so the window always ends at the top
   function automatic logic [31:0] romBase(input logic [2:0] sz);
      logic [31:0] b;
      b = ROM_BASE_256K;
      unique case (sz)
         ROM_2M:   b = ROM_BASE_2M;
         ROM_1M5:  b = ROM_BASE_1M5;
         ROM_1M:   b = ROM_BASE_1M;
         ROM_768K: b = ROM_BASE_768K;
         ROM_512K: b = ROM_BASE_512K;
         ROM_384K: b = ROM_BASE_384K;
         default:  b = ROM_BASE_256K; // Unused codes fall back to smallest
      endcase
      return b;
   endfunction

   // RAM upper limit for a capacity code
   // RAM always starts at address zero; only its end moves
   function automatic logic [31:0] ramTop(input logic [1:0] sz);
      logic [31:0] t;
      t = RAM_TOP_64K;
      unique case (sz)
         RAM_256K: t = RAM_TOP_256K;
         RAM_192K: t = RAM_TOP_192K;
         RAM_128K: t = RAM_TOP_128K;
         RAM_64K:  t = RAM_TOP_64K;
      endcase
      return t;
   endfunction

   // Region of an address under the current map
   function automatic amd_region_t decode(input logic [31:0] a);
      amd_region_t r;
      logic [31:0] rb;
      r  = AMD_REG_NONE;
      rb = romBase(romSize);
      // Priority settles any overlap: read window, alias, RAM, peripherals
      // The read window always ends at the top address: only its base is compared
      // RAM starts at address zero, so only its upper limit is compared
      // Each boot mode shares the single-chip map, so mode is not decoded
      // boot map same
      if (romEnable && a >= rb) begin
         r = AMD_REG_ROM;
      end else if (progEnable && a >= (rb & ALIAS_MASK) && a <= PROG_ALIAS_TOP) begin
         r = AMD_REG_ALIAS;
      end else if (a <= ramTop(ramSize)) begin
         r = AMD_REG_RAM;
      end else if (periphEnable && a >= PERIPH_BASE && a <= PERIPH_TOP) begin
         r = AMD_REG_PERIPH;
      end
      return r;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   amd_state_s_t st_ff;   // Registered state
   amd_state_s_t nxt_st;  // Next state
   amd_region_t  reqReg;  // Region of the incoming request

   // Access flow:
   //  - Memory and unmapped accesses answer on the cycle after the take
   //  - A peripheral write is acknowledged at once, then carried out over
   //    the latency of the addressed register, so the core runs on
   //  - A peripheral read holds the port until its data arrives
   //  - While a peripheral access is open the port refuses new requests,
   //    which is what lets a read-back see every earlier posted write
   //  - Latency is counted in reference ticks, not system clocks
   // Limitation: one peripheral access at a time; throughput was traded
   // for a simple ordering guarantee that needs no address compare

   // A process rather than an assign, so that size and enable changes
   // re-run the decode even while the address stands still
   // full space
   always_comb begin
      reqReg = decode(req.addr);
   end

   // Next-state logic
   // Pulses drop after one cycle unless a branch raises them again
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.rvalid   = 1'b0;
      nxt_st.romWrErr = 1'b0;
      unique case (st_ff.state)
         AMD_ST_IDLE: begin
            if (req.valid && st_ff.ready) begin
               nxt_st.region = reqReg;
               if (reqReg == AMD_REG_PERIPH && req.write && !st_ff.postPend) begin
                  // The port keeps its own copy while the write is posted
                  // posted write
                  nxt_st.postPend = 1'b1;
                  nxt_st.postAddr = req.addr;
                  nxt_st.postData = req.wdata;
                  nxt_st.preq     = '{1'b1, 1'b1, req.addr, req.wdata};
                  nxt_st.latCnt   = periphLat;
                  nxt_st.rvalid   = 1'b1; // Acknowledged before taking effect
                  nxt_st.state    = AMD_ST_WAIT;
                  nxt_st.ready    = 1'b0; // Only one write in flight at a time
               end else if (reqReg == AMD_REG_PERIPH && !req.write) begin
                  nxt_st.preq   = '{1'b1, 1'b0, req.addr, '0};
                  nxt_st.latCnt = periphLat;
                  nxt_st.state  = AMD_ST_WAIT;
                  nxt_st.ready  = 1'b0;
               end else begin
                  // Memory and unmapped: answer next cycle; ROM write flagged
                  nxt_st.rvalid   = 1'b1;
                  nxt_st.rdata    = '0;
                  nxt_st.romWrErr = req.write && reqReg == AMD_REG_ROM;
               end
            end
         end
         AMD_ST_WAIT: begin
            // Count down in reference clock ticks
            // A latency of zero is served as one tick, so the port never stalls
            if (refTick) begin
               if (st_ff.latCnt <= LAT_ONE) begin
                  nxt_st.state = AMD_ST_DONE;
               end else begin
                  nxt_st.latCnt = st_ff.latCnt - LAT_ONE;
               end
            end
         end
         AMD_ST_DONE: begin
            // Port released here; a posted write has now taken effect
            nxt_st.preq.valid = 1'b0;
            nxt_st.ready      = 1'b1;
            nxt_st.state      = AMD_ST_IDLE;
            if (st_ff.preq.write) begin
               nxt_st.postPend = 1'b0;
            end else begin
               // Sampled while the peripheral still sees the request
               // read after posted write
               nxt_st.rvalid = 1'b1;
               nxt_st.rdata  = periphRdata;
            end
         end
         default: begin
            // Unused state code: recover to an idle, ready port
            nxt_st.state = AMD_ST_IDLE;
            nxt_st.ready = 1'b1;
         end
      endcase
   end

   // State register
   // Reset leaves the port ready so a request can be taken at once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff       <= '0;
         st_ff.ready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every output is a field of the state register, with no logic after it
   assign reqReady    = st_ff.ready;
   assign rspValid    = st_ff.rvalid;
   assign rspData     = st_ff.rdata;
   assign rspRegion   = st_ff.region;
   assign romWriteErr = st_ff.romWrErr;
   assign periphReq   = st_ff.preq;

endmodule

//--- pkg/amd_pkg.sv
package amd_pkg;

   // ****************************************************************
   // Address map constants
   // ****************************************************************
   localparam logic [31:0] ADDR_LOW       = 32'h0000_0000; // Lowest byte address
   localparam logic [31:0] ADDR_TOP       = 32'hffff_ffff; // Highest byte address
   localparam logic [31:0] PROG_ALIAS_TOP = 32'h00ff_ffff; // Programming alias end
   localparam logic [31:0] PERIPH_BASE    = 32'h0008_0000; // Peripheral area start
   localparam logic [31:0] PERIPH_TOP     = 32'h000f_ffff; // Peripheral area end

   // ****************************************************************
   // Capacity selections
   // ****************************************************************
   localparam logic [2:0] ROM_2M   = 3'h0;
   localparam logic [2:0] ROM_1M5  = 3'h1;
   localparam logic [2:0] ROM_1M   = 3'h2;
   localparam logic [2:0] ROM_768K = 3'h3;
   localparam logic [2:0] ROM_512K = 3'h4;
   localparam logic [2:0] ROM_384K = 3'h5;
   localparam logic [2:0] ROM_256K = 3'h6;

   localparam logic [1:0] RAM_256K = 2'h0;
   localparam logic [1:0] RAM_192K = 2'h1;
   localparam logic [1:0] RAM_128K = 2'h2;
   localparam logic [1:0] RAM_64K  = 2'h3;

   // Read window bases; the alias base is the same value with the top byte cleared
   localparam logic [31:0] ROM_BASE_2M   = 32'hffe0_0000;
   localparam logic [31:0] ROM_BASE_1M5  = 32'hffe8_0000;
   localparam logic [31:0] ROM_BASE_1M   = 32'hfff0_0000;
   localparam logic [31:0] ROM_BASE_768K = 32'hfff4_0000;
   localparam logic [31:0] ROM_BASE_512K = 32'hfff8_0000;
   localparam logic [31:0] ROM_BASE_384K = 32'hfffa_0000;
   localparam logic [31:0] ROM_BASE_256K = 32'hfffc_0000;
   localparam logic [31:0] ALIAS_MASK    = 32'h00ff_ffff;

   localparam logic [31:0] RAM_TOP_256K = 32'h0003_ffff;
   localparam logic [31:0] RAM_TOP_192K = 32'h0002_ffff;
   localparam logic [31:0] RAM_TOP_128K = 32'h0001_ffff;
   localparam logic [31:0] RAM_TOP_64K  = 32'h0000_ffff;

   // Operating modes
   typedef enum logic [1:0] {
      AMD_MODE_SINGLE   = 2'h0,
      AMD_MODE_BOOT     = 2'h1,
      AMD_MODE_USERBOOT = 2'h3,
      AMD_MODE_USBBOOT  = 2'h2
   } amd_mode_t;

   // Target region codes
   typedef enum logic [2:0] {
      AMD_REG_NONE   = 3'h0,
      AMD_REG_RAM    = 3'h1,
      AMD_REG_ROM    = 3'h3,
      AMD_REG_ALIAS  = 3'h2,
      AMD_REG_PERIPH = 3'h6
   } amd_region_t;

   // Peripheral port state
   typedef enum logic [1:0] {
      AMD_ST_IDLE  = 2'h0,
      AMD_ST_WAIT  = 2'h1,
      AMD_ST_DONE  = 2'h3
   } amd_state_t;

   localparam logic [3:0] LAT_ONE = 4'h1; // Least latency count

   // Initiator request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } amd_req_t;

   // Peripheral side request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } amd_preq_t;

   // Block state
   typedef struct packed {
      amd_state_t  state;
      logic [3:0]  latCnt;
      logic        ready;
      logic        postPend;
      logic [31:0] postAddr;
      logic [31:0] postData;
      amd_preq_t   preq;
      logic        rvalid;
      logic [31:0] rdata;
      amd_region_t region;
      logic        romWrErr;
   } amd_state_s_t;

endpackage

//--- verif/amd_decoder_assertions.sv
`timescale 1ns/1ps
module amd_decoder_assertions
   import amd_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // Enables
   input wire logic        romEnable,
   input wire logic        progEnable,
   input wire logic        periphEnable,
   // Initiator side
   input wire amd_req_t    req,
   input wire logic        reqReady,
   input wire logic        rspValid,
   input wire logic [31:0] rspData,
   input wire amd_region_t rspRegion,
   input wire logic        romWriteErr,
   // Peripheral side
   input wire amd_preq_t   periphReq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic tk; // Request taken this edge
   assign tk = req.valid && reqReady;
   ram_map_a: assert property (tk && req.addr <= RAM_TOP_64K
      |=> rspValid && rspRegion == AMD_REG_RAM) else $error("RAM decode wrong");
   rom_map_a: assert property (tk && romEnable && req.addr >= ROM_BASE_256K
      |=> rspValid && rspRegion == AMD_REG_ROM) else $error("ROM decode wrong");
   alias_map_a: assert property (tk && progEnable && req.addr >= 32'h00fc_0000
      && req.addr <= PROG_ALIAS_TOP |=> rspRegion == AMD_REG_ALIAS) else $error("alias wrong");
   rom_write_a: assert property (tk && req.write && romEnable
      && req.addr >= ROM_BASE_256K |=> romWriteErr) else $error("ROM write not flagged");
   post_write_a: assert property (tk && req.write && periphEnable
      && req.addr inside {[PERIPH_BASE:PERIPH_TOP]} |=> rspValid && periphReq.valid && !reqReady)
      else $error("write not posted");
   busy_refuse_a: assert property (periphReq.valid |-> !reqReady)
      else $error("ready while busy");
   preq_hold_a: assert property (periphReq.valid ##1 periphReq.valid
      |-> $stable(periphReq.addr) && $stable(periphReq.wdata)) else $error("request moved");
   mem_zero_a: assert property (rspValid && rspRegion != AMD_REG_PERIPH
      |-> rspData == 32'h0) else $error("data not zero");
   lat_bound_a: assert property ($rose(periphReq.valid) |-> ##[1:60] !periphReq.valid)
      else $error("access hangs");
endmodule
bind amd_decoder amd_decoder_assertions chk (.*);

//--- verif/amd_periph_model.sv
`timescale 1ns/1ps
module amd_periph_model
   import amd_pkg::*;
(
   // Clock and request
   input wire logic      clk,
   input wire amd_preq_t periphReq,
   // Read data
   output logic [31:0]   periphRdata
);
   logic [31:0] mem [4];         // Four register words
   logic [31:0] last = 32'h0;    // Last word driven
   always @(posedge clk)
      if (periphReq.valid && periphReq.write) mem[periphReq.addr[3:2]] <= periphReq.wdata;
   always @(posedge clk) if (periphReq.valid) last <= periphRdata;
   // Idle bus shows the inverse, so a stale word never passes
   assign periphRdata = periphReq.valid ? mem[periphReq.addr[3:2]] : ~last;
endmodule

//--- verif/tb_address_map_decoder.sv
`timescale 1ns/1ps
module tb_address_map_decoder;
   import amd_pkg::*;
   logic clk = 0, sys_rst = 1, refTick = 0, tickAll = 0;
   logic [2:0] romSize = 3'h0;
   logic [1:0] ramSize = 2'h0;
   amd_mode_t opMode = AMD_MODE_SINGLE;
   logic romEnable = 1, progEnable = 1, periphEnable = 1;
   logic [3:0] periphLat = 4'h1;
   amd_req_t req = '0;
   logic reqReady, rspValid, romWriteErr, er;
   logic [31:0] rspData, periphRdata, rd;
   amd_region_t rspRegion, rg;
   amd_preq_t periphReq;
   int badCount = 0, compares = 0, cycles = 0, cyc;
   logic [31:0] rb [7] = '{ROM_BASE_2M, ROM_BASE_1M5, ROM_BASE_1M, ROM_BASE_768K,
      ROM_BASE_512K, ROM_BASE_384K, ROM_BASE_256K};
   logic [31:0] rt [4] = '{RAM_TOP_256K, RAM_TOP_192K, RAM_TOP_128K, RAM_TOP_64K};
   amd_decoder dut (.*);
   amd_periph_model peer (.*);
   initial forever #50 clk = ~clk;
   // Tick every other cycle unless held high
   always @(posedge clk) refTick <= tickAll | ~refTick;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 20000) begin
         badCount++;
         final_report();
      end
   end
   task chk(input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         badCount++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One access: hold until taken, then wait for the answer
   task acc(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      req <= '{1'b1, w, a, d};
      @(negedge clk);
      while (reqReady !== 1'b1) @(negedge clk);
      @(posedge clk);
      req <= '0;
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
      end while (rspValid !== 1'b1 && cyc < 80);
      rd = rspData;
      rg = rspRegion;
      er = romWriteErr;
   endtask
   task rchk(input logic [31:0] a, amd_region_t e);
      acc(1'b0, a, 32'h0);
      chk(rg, e);
   endtask
   task map_test();
      for (int i = 0; i < 7; i++) begin
         @(posedge clk) romSize <= 3'(i);
         rchk(rb[i], AMD_REG_ROM);
         rchk(rb[i] - 1, AMD_REG_NONE);
         rchk(rb[i] & ALIAS_MASK, AMD_REG_ALIAS);
         rchk((rb[i] & ALIAS_MASK) - 1, AMD_REG_NONE);
      end
      // Unused capacity code serves as the smallest part
      @(posedge clk) romSize <= 3'h7;
      rchk(ROM_BASE_256K, AMD_REG_ROM);
      rchk(ROM_BASE_384K, AMD_REG_NONE);
      rchk(ADDR_TOP, AMD_REG_ROM);
      rchk(PROG_ALIAS_TOP, AMD_REG_ALIAS);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk) ramSize <= 2'(j);
         rchk(rt[j], AMD_REG_RAM);
         rchk(rt[j] + 1, AMD_REG_NONE);
      end
      rchk(ADDR_LOW, AMD_REG_RAM);
   endtask
   task mode_test();
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) opMode <= amd_mode_t'(k);
         rchk(ROM_BASE_256K, AMD_REG_ROM);
         rchk(ROM_BASE_2M, AMD_REG_NONE);
      end
   endtask
   task enable_test();
      acc(1'b1, ADDR_TOP, 32'h5a);
      chk(er, 1'b1);
      @(posedge clk) {romEnable, progEnable, periphEnable} <= 3'h0;
      rchk(ADDR_TOP, AMD_REG_NONE);
      rchk(PROG_ALIAS_TOP, AMD_REG_NONE);
      rchk(PERIPH_BASE, AMD_REG_NONE);
      @(posedge clk) {romEnable, progEnable, periphEnable} <= 3'h7;
   endtask
   // write then read back; only listed words used
   task post_test();
      acc(1'b1, PERIPH_BASE, 32'haaaa_0001);
      acc(1'b1, PERIPH_BASE + 4, 32'hbbbb_0002);
      chk(cyc, 1);
      acc(1'b1, PERIPH_BASE, 32'hcccc_0003);
      acc(1'b0, PERIPH_BASE, 32'h0);
      chk(rd, 32'hcccc_0003);
      chk(rg, AMD_REG_PERIPH);
      acc(1'b0, PERIPH_BASE + 4, 32'h0);
      chk(rd, 32'hbbbb_0002);
   endtask
   task lat_test();
      int c1;
      @(posedge clk) tickAll <= 1'b1;
      acc(1'b0, PERIPH_BASE, 32'h0);
      c1 = cyc;
      @(posedge clk) periphLat <= 4'h4;
      acc(1'b0, PERIPH_BASE, 32'h0);
      chk(cyc - c1, 3);
      // Ticks every other cycle: four ticks must span at least seven cycles
      @(posedge clk) tickAll <= 1'b0;
      acc(1'b0, PERIPH_BASE, 32'h0);
      chk(cyc inside {9, 10}, 1'b1);
      @(posedge clk) tickAll <= 1'b1;
      @(posedge clk) periphLat <= 4'h0;
      acc(1'b0, PERIPH_BASE, 32'h0);
      chk(cyc, c1);
      @(posedge clk) tickAll <= 1'b0;
   endtask
   task final_report();
      if (badCount == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      map_test();
      mode_test();
      enable_test();
      post_test();
      lat_test();
      final_report();
   end
endmodule
